// ---- rtl/frs_pkg.sv ----
// Package for the frequency reference selector: widths, encodings, carriers.
// Assumes frequencies in 0.01 Hz steps and settings held static by the store.
package frs_pkg;

  localparam int FW = 16;
  localparam int SW = 17;
  localparam int AW = 13;
  localparam int YW = 14;
  localparam int CW = 20;
  localparam int ULW = 18;

  // Analog codes and the aux fraction use 4096 as 100 %.
  localparam int FRAC_SHIFT = 12;
  localparam int PCT_DIV = 100;
  localparam int SUP_DIV = 409600;
  // X*Y in 0.01 Hz units needs one division by 100.
  localparam int PROD_DIV = 100;

  localparam logic [15:0] KEYPAD_PRESET_RST = 16'h1388;
  localparam logic [15:0] FREQ_STEP = 16'h0001;

  typedef enum logic [3:0] {
    FRS_SEL_X    = 4'h0,
    FRS_SEL_COMB = 4'h1,
    FRS_SEL_XY   = 4'h2,
    FRS_SEL_XC   = 4'h3,
    FRS_SEL_YC   = 4'h4
  } frs_src_sel_t;

  typedef enum logic [3:0] {
    FRS_OP_SUM  = 4'h0,
    FRS_OP_DIFF = 4'h1,
    FRS_OP_MAX  = 4'h2,
    FRS_OP_MIN  = 4'h3,
    FRS_OP_MUL  = 4'h4
  } frs_op_t;

  typedef enum logic [2:0] {
    FRS_UL_DIGITAL = 3'h0,
    FRS_UL_AI1     = 3'h1,
    FRS_UL_AI2     = 3'h2,
    FRS_UL_COMM    = 3'h5
  } frs_ul_src_t;

  typedef enum logic [1:0] {
    FRS_LL_RUN     = 2'h0,
    FRS_LL_STOP    = 2'h1,
    FRS_LL_STANDBY = 2'h2
  } frs_ll_act_t;

  typedef struct packed {
    frs_op_t tens;
    frs_src_sel_t ones;
    logic aux_range_basis;
    logic [7:0] aux_range_percent;
    logic [15:0] keypad_preset_freq;
    logic run_direction_sel;
    logic [15:0] max_output_freq;
    frs_ul_src_t upper_limit_source;
    logic [15:0] upper_limit_freq;
    logic [15:0] upper_limit_offset;
    logic [15:0] lower_limit_freq;
    logic [15:0] start_freq;
    frs_ll_act_t below_lower_limit_action;
  } frs_cfg_t;

  typedef struct packed {
    logic [15:0] target_freq;
    logic reverse;
    logic [15:0] upper_limit;
    logic running;
    logic stop_req;
    logic standby;
    logic below_lower;
    logic torque_ctrl_en;
  } frs_out_t;

  localparam frs_out_t OUT_RST = '0;

endpackage

// ---- rtl/frs_clamp.sv ----
// Saturating limiter: passes a magnitude through or cuts it to a limit.
// Assumes W is at least 16; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module frs_clamp #(
  parameter int W = 20
) (
  // Value and limit
  input wire logic [W-1:0] val,
  input wire logic [15:0] lim,
  // Result
  output logic [15:0] res
);

  logic [W-1:0] lim_ext;
  logic over;

  assign lim_ext = W'(lim);
  assign over = val > lim_ext;
  assign res = over ? lim : val[15:0];

endmodule
`default_nettype wire

// ---- rtl/frs_select.sv ----
// Frequency reference selector: combines main X and aux Y, limits, direction.
// Assumes settings come from the parameter store and stay static while used.
//
// How it works
// [R1] Ones digit 0 takes X alone.
// [R2] Ones digit 1 takes combined X/Y result.
// [R3] Digit 2: switch input picks X or Y.
// [R4] Digit 3: switch input picks X or combined.
// [R5] Digit 4: switch input picks Y or combined.
// [R6] Tens digit 0 adds X and Y.
// [R7] Tens digit 1 subtracts Y from X.
// [R8] Tens digit 2 takes larger magnitude.
// [R9] Tens digit 3 takes smaller magnitude.
// [R10] Tens digit 4 multiplies X by Y.
// [R11] Aux range follows max frequency or X for the combined result; Y alone always uses max frequency.
// [R12] Keypad preset seeds the digital setting.
// [R13] Direction setting flips the run direction.
// [R14] Upper limit from digital, analog or comms.
// [R15] Analog full scale equals digital upper limit.
// [R16] Offset is added to analog upper limit.
// [R17] Torque control stops at the upper limit.
// [R18] Start at start frequency, detect low requests.
// [R19] Low request: run at limit, stop, standby.
// [R20] Store never gives X and Y one channel.
// [R21] Target under upper limit, limit under maximum; start_freq and low-request lower_limit_freq targets are not cut to it.
// [R22] Switch input sampled, selection changes on edges.
`timescale 1ns/1ps
`default_nettype none
module frs_select (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Settings from the parameter store
  input wire frs_pkg::frs_cfg_t cfg,
  // Source front ends
  input wire logic signed [frs_pkg::SW-1:0] x_freq,
  input wire logic signed [frs_pkg::YW-1:0] y_frac,
  input wire logic [frs_pkg::AW-1:0] analog_input_one,
  input wire logic [frs_pkg::AW-1:0] analog_input_two,
  input wire logic [15:0] comm_upper_limit,
  // Switching inputs and speed core feedback
  input wire logic src_switch,
  input wire logic run_cmd,
  input wire logic torque_mode,
  input wire logic [15:0] running_freq,
  // Digital setting adjust
  input wire logic preset_load,
  input wire logic up_step,
  input wire logic down_step,
  // Towards the speed core
  output var frs_pkg::frs_out_t status,
  output var logic [15:0] digital_setting
);

  localparam int CW = frs_pkg::CW;

  function automatic logic [CW-1:0] mag(input logic signed [CW-1:0] v);
    mag = v[CW-1] ? CW'(-v) : CW'(v);
  endfunction

  logic sw_reg;
  logic run_reg;
  logic torque_reg;
  logic signed [CW-1:0] sel_reg;
  logic signed [CW-1:0] sel_next;
  logic [15:0] ulim_reg;
  logic [15:0] ulim_next;
  logic [15:0] digi_reg;
  logic [15:0] digi_next;
  frs_pkg::frs_out_t out_reg;
  frs_pkg::frs_out_t out_next;

  // Source scaling. The aux fraction is relative to a base range.
  logic signed [CW-1:0] x_ext;
  logic [15:0] x_abs;
  logic [15:0] y_base;
  logic signed [31:0] y_alone_prod;
  logic signed [CW-1:0] y_alone;
  logic signed [47:0] y_sup_prod;
  logic signed [CW-1:0] y_sup;

  assign x_ext = CW'(x_freq);
  assign x_abs = 16'(mag(x_ext));
  assign y_base = cfg.aux_range_basis ? x_abs : cfg.max_output_freq; // [R11]
  assign y_alone_prod = 32'(y_frac) * $signed(32'(cfg.max_output_freq));
  assign y_alone = CW'(y_alone_prod >>> frs_pkg::FRAC_SHIFT);
  assign y_sup_prod = 48'(y_frac) * $signed(48'(y_base))
                    * $signed(48'(cfg.aux_range_percent)); // [R11]
  assign y_sup = CW'(y_sup_prod / $signed(48'(frs_pkg::SUP_DIV)));

  // Combining operations, all formed in parallel and picked by the tens digit.
  logic signed [CW-1:0] op_sum;
  logic signed [CW-1:0] op_diff;
  logic signed [CW-1:0] op_max;
  logic signed [CW-1:0] op_min;
  logic signed [39:0] mul_prod;
  logic signed [CW-1:0] op_mul;
  logic x_wins;
  logic signed [CW-1:0] comb;

  assign op_sum = x_ext + y_sup; // [R6]
  assign op_diff = x_ext - y_sup; // [R7]
  assign x_wins = mag(x_ext) >= mag(y_sup);
  assign op_max = x_wins ? x_ext : y_sup; // [R8]
  assign op_min = x_wins ? y_sup : x_ext; // [R9]
  assign mul_prod = 40'(x_ext) * 40'(y_sup);
  assign op_mul = CW'(mul_prod / $signed(40'(frs_pkg::PROD_DIV))); // [R10]

  assign comb = (cfg.tens == frs_pkg::FRS_OP_DIFF) ? op_diff :
                (cfg.tens == frs_pkg::FRS_OP_MAX)  ? op_max :
                (cfg.tens == frs_pkg::FRS_OP_MIN)  ? op_min :
                (cfg.tens == frs_pkg::FRS_OP_MUL)  ? op_mul : op_sum;

  // Source selection uses only the registered switch, so a bouncing input
  // can move the reference at most once per clock and never mid-cycle.
  logic is_comb;
  logic is_xy;
  logic is_xc;
  logic is_yc;
  logic use_y;
  logic use_c;

  assign is_comb = cfg.ones == frs_pkg::FRS_SEL_COMB;
  assign is_xy = cfg.ones == frs_pkg::FRS_SEL_XY;
  assign is_xc = cfg.ones == frs_pkg::FRS_SEL_XC;
  assign is_yc = cfg.ones == frs_pkg::FRS_SEL_YC;
  assign use_y = (is_xy && sw_reg) || (is_yc && !sw_reg); // [R3] [R5]
  assign use_c = is_comb || ((is_xc || is_yc) && sw_reg); // [R2] [R4] [R5]
  // Unknown digits fall back to X, the safest single source.
  assign sel_next = use_c ? comb : use_y ? y_alone : x_ext; // [R1]

  // Upper limit.
  localparam int AW_SEL = frs_pkg::AW;
  logic [AW_SEL-1:0] ai_sel;
  logic [28:0] ai_prod;
  logic [17:0] ai_lim;
  logic [17:0] ul_raw;
  logic ul_is_ai;

  assign ul_is_ai = (cfg.upper_limit_source == frs_pkg::FRS_UL_AI1)
                 || (cfg.upper_limit_source == frs_pkg::FRS_UL_AI2);
  assign ai_sel = (cfg.upper_limit_source == frs_pkg::FRS_UL_AI2) ?
                  analog_input_two : analog_input_one; // [R14]
  assign ai_prod = 29'(ai_sel) * 29'(cfg.upper_limit_freq); // [R15]
  assign ai_lim = 18'(ai_prod >> frs_pkg::FRAC_SHIFT)
                + 18'(cfg.upper_limit_offset); // [R16]
  // Reserved source codes behave as the digital setting.
  assign ul_raw = ul_is_ai ? ai_lim :
                  (cfg.upper_limit_source == frs_pkg::FRS_UL_COMM) ?
                  18'(comm_upper_limit) : 18'(cfg.upper_limit_freq); // [R14]

  frs_clamp #(
    .W(frs_pkg::ULW)
  ) u_ul_clamp (
    .val(ul_raw),
    .lim(cfg.max_output_freq),
    .res(ulim_next)
  ); // [R21]

  // Stage one: sample the inputs and hold the selected reference.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw_reg <= 1'b0;
      run_reg <= 1'b0;
      torque_reg <= 1'b0;
      sel_reg <= '0;
      ulim_reg <= '0;
    end else begin
      sw_reg <= src_switch; // [R22]
      run_reg <= run_cmd;
      torque_reg <= torque_mode;
      sel_reg <= sel_next;
      ulim_reg <= ulim_next;
    end
  end

  // Stage two: limit, low-request handling, direction and torque release.
  logic [CW-1:0] sel_mag;
  logic [15:0] tgt_clamped;
  logic below;
  logic starting;
  logic ul_reached;
  logic [15:0] tgt_freq;

  assign sel_mag = mag(sel_reg);

  frs_clamp #(
    .W(CW)
  ) u_tgt_clamp (
    .val(sel_mag),
    .lim(ulim_reg),
    .res(tgt_clamped)
  ); // [R21]

  assign starting = run_reg && !out_reg.running; // [R18]
  assign below = run_reg && !starting
              && (sel_mag < CW'(cfg.lower_limit_freq)); // [R18]
  assign ul_reached = running_freq >= ulim_reg; // [R17]

  assign tgt_freq =
    !run_reg ? 16'h0000 :
    starting ? cfg.start_freq : // [R18]
    (torque_reg && ul_reached) ? ulim_reg : // [R17]
    !below ? tgt_clamped :
    (cfg.below_lower_limit_action == frs_pkg::FRS_LL_RUN) ?
      cfg.lower_limit_freq : 16'h0000; // [R19]

  always_comb begin
    out_next = frs_pkg::OUT_RST;
    out_next.target_freq = tgt_freq;
    out_next.reverse = sel_reg[CW-1] ^ cfg.run_direction_sel; // [R13]
    out_next.upper_limit = ulim_reg;
    out_next.running = run_reg;
    out_next.below_lower = below;
    out_next.stop_req = below
      && (cfg.below_lower_limit_action == frs_pkg::FRS_LL_STOP); // [R19]
    out_next.standby = below
      && (cfg.below_lower_limit_action == frs_pkg::FRS_LL_STANDBY); // [R19]
    out_next.torque_ctrl_en = torque_reg && !ul_reached; // [R17]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= frs_pkg::OUT_RST;
    end else begin
      out_reg <= out_next;
    end
  end

  // Digital setting: starts from the keypad preset and steps up or down.
  // A loaded preset above maximum is cut and up steps stop at maximum; the reset value KEYPAD_PRESET_RST is not cut.
  logic [15:0] preset_cut;

  assign preset_cut = (cfg.keypad_preset_freq > cfg.max_output_freq) ?
                      cfg.max_output_freq : cfg.keypad_preset_freq;
  assign digi_next =
    preset_load ? preset_cut : // [R12]
    (up_step && digi_reg < cfg.max_output_freq) ? digi_reg + frs_pkg::FREQ_STEP :
    (down_step && digi_reg != 16'h0000) ? digi_reg - frs_pkg::FREQ_STEP :
    digi_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      digi_reg <= frs_pkg::KEYPAD_PRESET_RST; // [R12]
    end else begin
      digi_reg <= digi_next;
    end
  end

  assign status = out_reg;
  assign digital_setting = digi_reg;

  // Checks on the selection path and the limited outputs.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_x_only: assert property ( // [R1]
    cfg.ones == frs_pkg::FRS_SEL_X |=> sel_reg == $past(x_ext))
    else $error("X-only mode did not pass X");

  a_comb_used: assert property ( // [R2]
    is_comb |=> sel_reg == $past(comb))
    else $error("combined mode did not pass the combined result");

  a_switch_xy: assert property ( // [R3]
    is_xy |=> sel_reg == ($past(sw_reg) ? $past(y_alone) : $past(x_ext)))
    else $error("X/Y switchover picked the wrong source");

  a_switch_xc: assert property ( // [R4]
    is_xc |=> sel_reg == ($past(sw_reg) ? $past(comb) : $past(x_ext)))
    else $error("X/combined switchover picked the wrong source");

  a_switch_yc: assert property ( // [R5]
    is_yc |=> sel_reg == ($past(sw_reg) ? $past(comb) : $past(y_alone)))
    else $error("Y/combined switchover picked the wrong source");

  a_sum_path: assert property ( // [R6]
    is_comb && cfg.tens == frs_pkg::FRS_OP_SUM
    |=> sel_reg == $past(x_ext + y_sup))
    else $error("sum operation wrong");

  a_diff_path: assert property ( // [R7]
    is_comb && cfg.tens == frs_pkg::FRS_OP_DIFF
    |=> sel_reg == $past(x_ext - y_sup))
    else $error("difference operation wrong");

  a_max_pick: assert property ( // [R8]
    is_comb && cfg.tens == frs_pkg::FRS_OP_MAX
    |=> mag(sel_reg) >= $past(mag(x_ext)) && mag(sel_reg) >= $past(mag(y_sup)))
    else $error("larger-magnitude pick wrong");

  a_min_pick: assert property ( // [R9]
    is_comb && cfg.tens == frs_pkg::FRS_OP_MIN
    |=> mag(sel_reg) <= $past(mag(x_ext)) && mag(sel_reg) <= $past(mag(y_sup)))
    else $error("smaller-magnitude pick wrong");

  a_target_limit: assert property ( // [R21]
    status.target_freq <= status.upper_limit
    || $past(starting) || $past(below))
    else $error("target above the upper limit");

  a_digital_ul: assert property ( // [R14]
    cfg.upper_limit_source == frs_pkg::FRS_UL_DIGITAL
    && cfg.upper_limit_freq <= cfg.max_output_freq
    |=> ##1 status.upper_limit == $past(cfg.upper_limit_freq, 2))
    else $error("digital upper limit not applied");

  a_dir_fwd: assert property ( // [R13]
    run_reg && sel_reg > 0 && !cfg.run_direction_sel |=> !status.reverse)
    else $error("forward request ran reverse");

  // Holding the upper limit under torque control outranks the low-request
  // action, so the stop check only covers cycles without that hold.
  a_low_stop: assert property ( // [R19]
    below && cfg.below_lower_limit_action == frs_pkg::FRS_LL_STOP
    && !(torque_reg && ul_reached)
    |=> status.stop_req && status.target_freq == 16'h0000)
    else $error("stop action not taken below the lower limit");

  a_torque_off: assert property ( // [R17]
    run_reg && !starting && torque_reg && running_freq >= ulim_reg
    |=> !status.torque_ctrl_en && status.target_freq == $past(ulim_reg))
    else $error("torque control kept past the upper limit");

  a_start_freq: assert property ( // [R18]
    run_reg && !status.running |=> status.target_freq == $past(cfg.start_freq))
    else $error("run did not begin at the start frequency");

  a_preset_load: assert property ( // [R12]
    preset_load && cfg.keypad_preset_freq <= cfg.max_output_freq
    |=> digital_setting == $past(cfg.keypad_preset_freq))
    else $error("keypad preset not loaded");

  c_switch_toggle: cover property (is_xy ##1 $changed(sw_reg));
  c_low_standby: cover property (below
    && cfg.below_lower_limit_action == frs_pkg::FRS_LL_STANDBY);
  c_torque_release: cover property (status.torque_ctrl_en ##1 !status.torque_ctrl_en);
  c_mul_mode: cover property (is_comb && cfg.tens == frs_pkg::FRS_OP_MUL ##1 run_reg);

endmodule
`default_nettype wire

// ---- bench/frs_speed_core_model.sv ----
// Speed core model: reports the running frequency back to the selector.
// Assumes it follows the target at once unless the bench asks for an overspeed.
`timescale 1ns/1ps
`default_nettype none
module frs_speed_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Reference from the selector
  input wire frs_pkg::frs_out_t status,
  // Scenario control
  input wire logic overspeed,
  // Feedback
  output logic [15:0] running_freq
);
  // An overspeed stands for a load that broke away while under torque control.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      running_freq <= 16'h0000;
    end else if (overspeed) begin
      running_freq <= status.upper_limit + 16'h0064;
    end else begin
      running_freq <= status.running ? status.target_freq : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_frequency_reference_select.sv ----
// Self-checking bench for the frequency reference selector.
// Assumes the speed core model closes the feedback loop.
`timescale 1ns/1ps
`default_nettype none
module tb_frequency_reference_select;
  logic clk, rstn, src_switch, run_cmd, torque_mode, preset_load, up_step, down_step, overspeed;
  frs_pkg::frs_cfg_t cfg;
  logic signed [frs_pkg::SW-1:0] x_freq;
  logic signed [frs_pkg::YW-1:0] y_frac;
  logic [frs_pkg::AW-1:0] ai_one, ai_two;
  logic [15:0] comm_ul, running_freq, digital_setting;
  frs_pkg::frs_out_t status;
  int mismatches, samples_checked;

  frs_select frs_select_inst (.clk(clk), .rstn(rstn), .cfg(cfg), .x_freq(x_freq),
    .y_frac(y_frac), .analog_input_one(ai_one), .analog_input_two(ai_two),
    .comm_upper_limit(comm_ul), .src_switch(src_switch), .run_cmd(run_cmd),
    .torque_mode(torque_mode), .running_freq(running_freq), .preset_load(preset_load),
    .up_step(up_step), .down_step(down_step), .status(status),
    .digital_setting(digital_setting));
  frs_speed_core_model frs_speed_core_model_inst (.clk(clk), .rstn(rstn), .status(status),
    .overspeed(overspeed), .running_freq(running_freq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string msg);
    samples_checked++;
    if (seen !== expv) begin
      mismatches++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, expv);
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic longint mag(input longint v);
    return (v < 0) ? -v : v;
  endfunction

  function automatic longint exp_ulim();
    longint u;
    case (cfg.upper_limit_source)
      frs_pkg::FRS_UL_AI1: u = longint'(ai_one) * cfg.upper_limit_freq / 4096
        + cfg.upper_limit_offset;
      frs_pkg::FRS_UL_AI2: u = longint'(ai_two) * cfg.upper_limit_freq / 4096
        + cfg.upper_limit_offset;
      frs_pkg::FRS_UL_COMM: u = comm_ul;
      default: u = cfg.upper_limit_freq;
    endcase
    return (u > cfg.max_output_freq) ? longint'(cfg.max_output_freq) : u;
  endfunction

  // Stimulus keeps every division exact, so truncation never decides a result.
  function automatic longint exp_sel();
    longint x, ya, ys, base, c;
    x = x_freq;
    ya = longint'(y_frac) * longint'(cfg.max_output_freq) / 4096;
    base = cfg.aux_range_basis ? mag(x) : longint'(cfg.max_output_freq);
    ys = longint'(y_frac) * base * longint'(cfg.aux_range_percent) / 409600;
    case (cfg.tens)
      frs_pkg::FRS_OP_DIFF: c = x - ys;
      frs_pkg::FRS_OP_MAX: c = (mag(ys) > mag(x)) ? ys : x;
      frs_pkg::FRS_OP_MIN: c = (mag(ys) <= mag(x)) ? ys : x;
      frs_pkg::FRS_OP_MUL: c = x * ys / 100;
      default: c = x + ys;
    endcase
    case (cfg.ones)
      frs_pkg::FRS_SEL_COMB: return c;
      frs_pkg::FRS_SEL_XY: return src_switch ? ya : x;
      frs_pkg::FRS_SEL_XC: return src_switch ? c : x;
      frs_pkg::FRS_SEL_YC: return src_switch ? c : ya;
      default: return x;
    endcase
  endfunction

  initial begin
    #50000;
    mismatches++;
    print_verdict();
  end

  initial begin
    longint s, ul, m;
    int k;
    rstn = 1'b0;
    {src_switch, run_cmd, torque_mode, preset_load, up_step, down_step, overspeed} = '0;
    cfg = '0;
    cfg.max_output_freq = 16'h2710;
    cfg.upper_limit_freq = 16'h1F40;
    cfg.upper_limit_offset = 16'h01F4;
    cfg.start_freq = 16'h0064;
    x_freq = 17'h007D0;
    y_frac = 14'h0000;
    {ai_one, ai_two, comm_ul} = '0;
    void'($urandom(32'h293BA8FF));
    step(5);
    check(digital_setting, 16'h1388, "preset at reset");
    rstn = 1'b1;
    step(4);
    check(status.target_freq, 16'h0000, "idle target");
    run_cmd = 1'b1;
    step(2);
    check(status.running, 16'h0001, "running");
    check(status.target_freq, 16'h0064, "start target");
    // Main and aux are separate ports here, so they never share a channel.
    for (int i = 0; i < 75; i++) begin
      cfg.ones = frs_pkg::frs_src_sel_t'(4'(i % 5));
      cfg.tens = frs_pkg::frs_op_t'(4'((i / 5) % 5));
      cfg.aux_range_basis = 1'($urandom_range(1, 0));
      cfg.aux_range_percent = ($urandom_range(1, 0) == 1) ? 8'h64 : 8'h32;
      cfg.run_direction_sel = 1'($urandom_range(1, 0));
      k = $urandom_range(4, 0);
      cfg.upper_limit_source = frs_pkg::frs_ul_src_t'((k == 3) ? 3'h5 : 3'(k));
      x_freq = 17'(400 * (int'($urandom_range(20, 0)) - 10));
      y_frac = 14'(1024 * (int'($urandom_range(8, 0)) - 4));
      ai_one = 13'(512 * $urandom_range(8, 0));
      ai_two = 13'(512 * $urandom_range(8, 0));
      comm_ul = 16'($urandom_range(12000, 0));
      src_switch = 1'($urandom_range(1, 0));
      step(4);
      s = exp_sel();
      ul = exp_ulim();
      m = mag(s);
      check(status.upper_limit, 16'(ul), "upper limit");
      check(status.target_freq, 16'((m > ul) ? ul : m), "target");
      check(status.reverse, 16'((s < 0) ^ cfg.run_direction_sel), "direction");
    end
    cfg.ones = frs_pkg::FRS_SEL_XY;
    cfg.upper_limit_source = frs_pkg::FRS_UL_DIGITAL;
    x_freq = 17'h00FA0;
    y_frac = 14'h1000;
    src_switch = 1'b0;
    step(4);
    src_switch = 1'b1;
    step(2);
    check(status.target_freq, 16'h0FA0, "switch early");
    step(1);
    check(status.target_freq, 16'h1F40, "switch taken");
    cfg.ones = frs_pkg::FRS_SEL_X;
    x_freq = 17'h00190;
    cfg.lower_limit_freq = 16'h03E8;
    for (int a = 0; a < 3; a++) begin
      cfg.below_lower_limit_action = frs_pkg::frs_ll_act_t'(2'(a));
      step(4);
      check(status.below_lower, 16'h0001, "below lower");
      check(status.target_freq, (a == 0) ? 16'h03E8 : 16'h0000, "lower action");
      check(status.stop_req, 16'(a == 1), "stop");
      check(status.standby, 16'(a == 2), "standby");
    end
    cfg.lower_limit_freq = 16'h0000;
    cfg.below_lower_limit_action = frs_pkg::FRS_LL_RUN;
    x_freq = 17'h00FA0;
    torque_mode = 1'b1;
    overspeed = 1'b1;
    step(6);
    check(status.torque_ctrl_en, 16'h0000, "torque off");
    check(status.target_freq, 16'h1F40, "torque limit");
    {torque_mode, overspeed} = '0;
    cfg.keypad_preset_freq = 16'h2EE0;
    preset_load = 1'b1;
    step(1);
    preset_load = 1'b0;
    up_step = 1'b1;
    step(3);
    up_step = 1'b0;
    step(1);
    check(digital_setting, 16'h2710, "preset capped");
    down_step = 1'b1;
    step(5);
    down_step = 1'b0;
    step(1);
    check(digital_setting, 16'h270B, "step down");
    cfg.keypad_preset_freq = 16'h0002;
    {preset_load, up_step} = 2'b11;
    step(1);
    {preset_load, up_step} = 2'b00;
    step(2);
    check(digital_setting, 16'h0002, "load first");
    down_step = 1'b1;
    step(4);
    down_step = 1'b0;
    step(1);
    check(digital_setting, 16'h0000, "floor");
    print_verdict();
  end
endmodule
`default_nettype wire
